/* rtl/acc_ctrl.sv */
// acc_ctrl: control logic of a 12-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
//Contract
// (R01) Converter clock is system clock divided by 1,2,4,8,16,32 per select code.
// (R02) Software programs the divider select before enabling and starting.
// (R03) Converter powered only while the power-down bit is zero.
// (R04) Software waits a settling delay after power-up before starting.
// (R05) Software should power the converter down whenever unused.
// (R06) Reference select high routes external reference pin, disables its other functions.
// (R07) Each set pin enable makes that pin an analog input, original function off.
// (R08) Pull-high is disconnected from a pin selected as analog input.
// (R09) A set pin enable overrides the port direction setting.
// (R10) Conversion starts on a complete low-high-low pulse of the start bit.
// (R11) Active flag drops at completion; result registers then hold valid data.
// (R12) Interrupt reaches processor only with global, multi-function, converter enables set.
// (R13) Each conversion takes exactly 16 converter clock periods.
// (R14) Conversion runs in hardware without stalling the processor.
// (R15) Result is 12-bit unsigned, full scale fff.
// (R16) Software selects channel and pin enables before starting.
// (R17) Channel select routes inputs 0..5, op amp one, op amp two.
// (R18) While start is high, converter held reset and active flag forced one.
// (R19) Active flag high throughout a conversion and one after reset.
// (R20) Completion sets the interrupt request flag, then interrupt if enabled.
// (R21) Result, flag clear and request set update in the same cycle.
// (R22) Undefined divider codes fall back to the slowest rate safely.
module acc_ctrl
    import acc_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        SRST_I,
    input  wire logic [2:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    input  wire logic        COMPARE_I,       // analog input is at or above the trial code
    input  wire logic [5:0]  PORT_DIR_OE_I,   // port direction register: pin drives when high
    input  wire logic [5:0]  PULLUP_EN_I,     // programmed pull-high enables
    output logic      [11:0] DAC_TRIAL_O,
    output logic      [2:0]  CHANNEL_SEL_O,
    output logic             CONV_POWER_ON_O,
    output logic             CONV_RESET_O,
    output logic             REF_EXT_SEL_O,
    output logic             VREF_PIN_SHARED_DIS_O,
    output logic      [5:0]  ANALOG_IN_EN_O,
    output logic      [5:0]  PIN_OUT_EN_O,
    output logic      [5:0]  PULLUP_ON_O,
    output logic             CONV_DONE_O,
    output logic             INT_O
);
    // tick counter end points; both fit the four-bit counter
    localparam logic [3:0] LAST_TICK = 4'(ACC_CONV_TICKS - 1);
    localparam logic [3:0] BIT_TICKS = 4'(ACC_RES_BITS);

    // software-visible state
    // the active flag is kept apart from the engine state so it can read one after reset
    logic        start_q;
    logic [2:0]  ch_q;
    logic        pd_q;
    logic        ref_q;
    logic [2:0]  div_q;
    logic [5:0]  pins_q;
    logic        gie_q;
    logic        mfe_q;
    logic        cie_q;
    logic        req_q;
    logic        active_q;
    logic [11:0] result_q;
    logic [7:0]  rdata_q;

    // conversion engine state
    // the trial output is a registered copy of the approximation register
    acc_state_e  state_q;
    acc_state_e  state_d;
    logic [3:0]  tcnt_q;
    logic [11:0] sar_q;
    logic [11:0] sar_d;
    logic        tick;

    // register decode
    // read-only and unimplemented bits simply have no write path
    wire wr_cmd   = WR_I && (ADDR_I == ACC_OFS_CMD);
    wire wr_setup = WR_I && (ADDR_I == ACC_OFS_SETUP);
    wire wr_pins  = WR_I && (ADDR_I == ACC_OFS_PINS);
    wire wr_int   = WR_I && (ADDR_I == ACC_OFS_INT);
    wire start_wr = WDATA_I[ACC_CMD_START_BIT];

    // start edges: a rise holds the converter, the following fall launches it
    // writing the start bit with no change is ignored, so a repeated write never re-arms
    wire start_rise = wr_cmd && start_wr && !start_q;
    wire start_fall = wr_cmd && !start_wr && start_q;  // R10

    // completion on the last of sixteen converter clocks; a restart or a power-down
    // in that very cycle wins, so an interrupted conversion never posts a result
    wire done = (state_q == ACC_CONV) && tick && (tcnt_q == LAST_TICK)  // R13
                && !start_rise && !pd_q;  // R18 R03

    // bit under trial during the first twelve ticks, msb first
    // the index wraps past zero after tick twelve, but judging masks it off there
    wire [3:0]  bit_idx = 4'(ACC_RES_BITS - 1) - tcnt_q;
    wire        judging = (state_q == ACC_CONV) && tick && (tcnt_q < BIT_TICKS);

    // converter clock ticks; the divider sits in phase zero outside a conversion so
    // the first tick always lands one full converter period after the start pulse,
    // which keeps the conversion time exact for every divider setting
    acc_clkdiv acc_clkdiv_i (
        .clk_i   (CLOCK_I),
        .srst_i  (SRST_I),
        .clear_i (state_q != ACC_CONV),  // phase aligned to the start pulse
        .sel_i   (div_q),
        .tick_o  (tick)
    );

    // next state; power-down aborts a running conversion without a result
    // the held state is the start bit sitting high: the converter stays in reset there
    // and only the falling write launches a conversion, so a stuck start never converts
    // a start that falls while powered down is dropped rather than queued
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACC_IDLE: if (start_rise) state_d = ACC_HELD;
            ACC_HELD: if (start_fall) state_d = pd_q ? ACC_IDLE : ACC_CONV;  // R10 R03
            ACC_CONV: begin
                if (start_rise)       state_d = ACC_HELD;  // R18
                else if (pd_q || done) state_d = ACC_IDLE;  // R03
            end
            default:  state_d = ACC_IDLE;
        endcase
    end

    // successive approximation: keep or drop the bit on trial, seed the next one
    // twelve of the sixteen ticks decide bits; the last four leave the code alone and
    // only pad the conversion out to its fixed length
    // the register reseeds to mid-scale whenever the engine is not converting
    always_comb begin
        sar_d = sar_q;
        if (state_q != ACC_CONV) begin
            sar_d = 12'h800;
        end else if (judging) begin
            sar_d[bit_idx] = COMPARE_I;  // R15
            if (bit_idx != 4'h0) begin
                sar_d[bit_idx - 4'h1] = 1'b1;
            end
        end
    end

    // engine registers run beside the processor, which is never stalled
    // the tick counter only moves on converter ticks and restarts with every conversion,
    // so a restart mid-conversion begins again from the top bit
    // nothing here waits on software, so a slow poll cannot stretch the conversion
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            state_q <= ACC_IDLE;
            tcnt_q  <= 4'h0;
            sar_q   <= 12'h800;
        end else begin
            state_q <= state_d;  // R14
            sar_q   <= sar_d;
            tcnt_q  <= (state_q != ACC_CONV) ? 4'h0 : (tick ? tcnt_q + 4'h1 : tcnt_q);
        end
    end

    // control registers written by software
    // fields take effect at the write edge; changing the divider or the channel during a
    // conversion is not blocked, software is expected to set them up beforehand
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            start_q <= 1'b0;
            ch_q    <= ACC_RST_CH;
            pd_q    <= ACC_RST_PD;
            ref_q   <= ACC_RST_REF;
            div_q   <= ACC_RST_DIV;
            pins_q  <= ACC_RST_PINS;
            gie_q   <= 1'b0;
            mfe_q   <= 1'b0;
            cie_q   <= 1'b0;
        end else begin
            if (wr_cmd) begin
                start_q <= start_wr;
                ch_q    <= WDATA_I[ACC_CMD_CH_LSB +: 3];
            end
            if (wr_setup) begin
                pd_q  <= WDATA_I[ACC_SET_PD_BIT];
                ref_q <= WDATA_I[ACC_SET_REF_BIT];
                div_q <= WDATA_I[ACC_SET_DIV_LSB +: 3];
            end
            if (wr_pins) begin
                pins_q <= WDATA_I[5:0];
            end
            if (wr_int) begin
                gie_q <= WDATA_I[ACC_INT_GIE_BIT];
                mfe_q <= WDATA_I[ACC_INT_MFE_BIT];
                cie_q <= WDATA_I[ACC_INT_CIE_BIT];
            end
        end
    end

    // status: flag, result and request move together; set wins over a software clear
    // posting all three in one edge means a poll that sees the flag low never reads a
    // stale result; a software clear landing on the completion edge is lost on purpose,
    // so a finished conversion can never go unreported
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            active_q <= 1'b1;  // R19
            result_q <= 12'h000;
            req_q    <= 1'b0;
        end else begin
            if (done) begin
                active_q <= 1'b0;  // R11 R21
                result_q <= sar_d;  // R21
                req_q    <= 1'b1;  // R20
            end else begin
                if (start_rise) begin
                    active_q <= 1'b1;  // R18
                end
                if (wr_int && !WDATA_I[ACC_INT_REQ_BIT]) begin
                    req_q <= 1'b0;
                end
            end
        end
    end

    // read mux; unmapped offsets return zero
    // the two result bytes are not latched against each other: reading them across a
    // completion edge can pair bytes from two conversions, so read after the flag drops
    // and before the next start
    wire [7:0] rd_cmd   = {start_q, active_q, 3'h0, ch_q};
    wire [7:0] rd_setup = {ACC_SET_TOP_RD, pd_q, ref_q, 2'h0, div_q};
    wire [7:0] rd_int   = {4'h0, req_q, cie_q, mfe_q, gie_q};
    wire [7:0] rd_mux   = (ADDR_I == ACC_OFS_CMD)    ? rd_cmd :
                          (ADDR_I == ACC_OFS_SETUP)  ? rd_setup :
                          (ADDR_I == ACC_OFS_PINS)   ? {2'h0, pins_q} :
                          (ADDR_I == ACC_OFS_RES_LO) ? result_q[7:0] :
                          (ADDR_I == ACC_OFS_RES_HI) ? {4'h0, result_q[11:8]} :
                          (ADDR_I == ACC_OFS_INT)    ? rd_int : 8'h00;

    // read data stand only in the cycle after the strobe
    // returning zero otherwise means stale data never shows outside a read cycle
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= RD_I ? rd_mux : 8'h00;
        end
    end

    // converter-side controls, registered so the analog side sees clean levels
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            DAC_TRIAL_O     <= 12'h800;
            CHANNEL_SEL_O   <= ACC_RST_CH;
            CONV_POWER_ON_O <= 1'b0;
            CONV_RESET_O    <= 1'b1;
        end else begin
            DAC_TRIAL_O     <= sar_d;
            CHANNEL_SEL_O   <= ch_q;  // R17
            CONV_POWER_ON_O <= !pd_q;  // R03
            CONV_RESET_O    <= (state_d != ACC_CONV);  // R18
        end
    end

    // reference selection; the shared functions of the reference pin go with it
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            REF_EXT_SEL_O         <= 1'b0;
            VREF_PIN_SHARED_DIS_O <= 1'b0;
        end else begin
            REF_EXT_SEL_O         <= ref_q;  // R06
            VREF_PIN_SHARED_DIS_O <= ref_q;  // R06
        end
    end

    // pin routing: an analog pin loses its driver and its pull-high whatever the port
    // direction register says, so software need not reconfigure the port first
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            ANALOG_IN_EN_O <= 6'h00;
            PIN_OUT_EN_O   <= 6'h00;
            PULLUP_ON_O    <= 6'h00;
        end else begin
            ANALOG_IN_EN_O <= pins_q;  // R07
            PIN_OUT_EN_O   <= PORT_DIR_OE_I & ~pins_q;  // R09 R07
            PULLUP_ON_O    <= PULLUP_EN_I & ~pins_q;  // R08
        end
    end

    // completion pulse and interrupt line
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            CONV_DONE_O <= 1'b0;
            INT_O       <= 1'b0;
        end else begin
            CONV_DONE_O <= done;
            // a request already pending still interrupts once all enables are set
            INT_O       <= (req_q || done) && gie_q && mfe_q && cie_q;  // R12 R20
        end
    end

    assign RDATA_O = rdata_q;
endmodule // acc_ctrl
`default_nettype wire

/* rtl/acc_pkg.sv */
// acc_pkg: constants shared by the converter control block
package acc_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] ACC_OFS_CMD    = 3'h0;  // converter_command_register
    localparam logic [2:0] ACC_OFS_SETUP  = 3'h1;  // converter_setup_register
    localparam logic [2:0] ACC_OFS_PINS   = 3'h2;  // analog_pin_config_register
    localparam logic [2:0] ACC_OFS_RES_LO = 3'h3;  // result bits 7..0
    localparam logic [2:0] ACC_OFS_RES_HI = 3'h4;  // result bits 11..8
    localparam logic [2:0] ACC_OFS_INT    = 3'h5;  // interrupt enables and request

    // command register fields
    localparam int ACC_CMD_START_BIT  = 7;
    localparam int ACC_CMD_ACTIVE_BIT = 6;
    localparam int ACC_CMD_CH_LSB     = 0;
    // setup register fields
    localparam int ACC_SET_PD_BIT     = 6;
    localparam int ACC_SET_REF_BIT    = 5;
    localparam int ACC_SET_DIV_LSB    = 0;
    // interrupt register fields
    localparam int ACC_INT_GIE_BIT    = 0;
    localparam int ACC_INT_MFE_BIT    = 1;
    localparam int ACC_INT_CIE_BIT    = 2;
    localparam int ACC_INT_REQ_BIT    = 3;

    // reset values
    localparam logic [2:0] ACC_RST_CH     = 3'h0;
    localparam logic       ACC_RST_PD     = 1'b0;
    localparam logic       ACC_RST_REF    = 1'b0;
    localparam logic [2:0] ACC_RST_DIV    = 3'h0;
    localparam logic [5:0] ACC_RST_PINS   = 6'h00;
    localparam logic       ACC_SET_TOP_RD = 1'b1;  // unimplemented setup bit 7 reads one

    // converter clock divider select codes
    localparam logic [2:0] ACC_DIV_1  = 3'h4;
    localparam logic [2:0] ACC_DIV_2  = 3'h0;
    localparam logic [2:0] ACC_DIV_4  = 3'h5;
    localparam logic [2:0] ACC_DIV_8  = 3'h1;
    localparam logic [2:0] ACC_DIV_16 = 3'h6;
    localparam logic [2:0] ACC_DIV_32 = 3'h2;

    // conversion timing in converter clock periods
    localparam int ACC_CONV_TICKS = 16;
    localparam int ACC_RES_BITS   = 12;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_HELD,
        ACC_CONV
    } acc_state_e;
endpackage : acc_pkg

/* rtl/acc_clkdiv.sv */
// acc_clkdiv: converter clock tick generator from the system clock
`timescale 1ns/1ps
`default_nettype none
module acc_clkdiv
    import acc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       clear_i,   // restart the phase at a conversion start
    input  wire logic [2:0] sel_i,
    output logic            tick_o     // one system clock pulse per converter clock
);
    logic [4:0] lim;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic       tick_q;

    // divider code to terminal count; undefined codes fall back to the slowest rate
    always_comb begin
        case (sel_i)
            ACC_DIV_1:  lim = 5'h00;  // R01
            ACC_DIV_2:  lim = 5'h01;
            ACC_DIV_4:  lim = 5'h03;
            ACC_DIV_8:  lim = 5'h07;
            ACC_DIV_16: lim = 5'h0f;
            ACC_DIV_32: lim = 5'h1f;
            default:    lim = 5'h1f;  // R22
        endcase
    end

    assign cnt_d = (clear_i || cnt_q >= lim) ? 5'h00 : cnt_q + 5'h01;

    // phase counter and registered tick
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q  <= 5'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= !clear_i && (cnt_q >= lim);
        end
    end

    assign tick_o = tick_q;
endmodule // acc_clkdiv
`default_nettype wire

/* testbench/acc_analog_model.sv */
// acc_analog_model: ideal comparator standing for the selected analog input
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
    input  wire logic [11:0] trial_i,
    input  wire logic [11:0] level_i,  // input level as a code, fff is full scale
    input  wire logic [2:0]  chan_i,
    output logic             compare_o
);
    // each channel sees a slightly different level so a wrong route shows in the result
    wire logic [11:0] chan_level = level_i ^ {9'h000, chan_i};
    // no offset modelled: level k converts to code k
    assign compare_o = (chan_level >= trial_i);
endmodule // acc_analog_model
`default_nettype wire

/* testbench/acc_ctrl_checker.sv */
// acc_ctrl_checker: port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_checker
    import acc_pkg::*;
(
    input wire logic       CLOCK_I,
    input wire logic       SRST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic [5:0] PORT_DIR_OE_I,
    input wire logic [5:0] PULLUP_EN_I,
    input wire logic [2:0] CHANNEL_SEL_O,
    input wire logic       CONV_POWER_ON_O,
    input wire logic       CONV_RESET_O,
    input wire logic       REF_EXT_SEL_O,
    input wire logic       VREF_PIN_SHARED_DIS_O,
    input wire logic [5:0] ANALOG_IN_EN_O,
    input wire logic [5:0] PIN_OUT_EN_O,
    input wire logic [5:0] PULLUP_ON_O,
    input wire logic       CONV_DONE_O,
    input wire logic       INT_O
);
    // bus decodes seen from outside
    wire logic       wr_cmd = WR_I && (ADDR_I == ACC_OFS_CMD);
    wire logic       wr_int = WR_I && (ADDR_I == ACC_OFS_INT);
    wire logic       wr_go  = wr_cmd && WDATA_I[ACC_CMD_START_BIT];
    wire logic [2:0] ch_w   = WDATA_I[2:0];
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    // stable sources only: the pin outputs lag their register by a cycle
    a_pins_drive: assert property (!$past(SRST_I) && $stable(ANALOG_IN_EN_O) &&
        $stable(PORT_DIR_OE_I) |-> PIN_OUT_EN_O == (PORT_DIR_OE_I & ~ANALOG_IN_EN_O))
        else $error("pin drive kept on an analog pin");
    a_pins_pull: assert property (!$past(SRST_I) && $stable(ANALOG_IN_EN_O) &&
        $stable(PULLUP_EN_I) |-> PULLUP_ON_O == (PULLUP_EN_I & ~ANALOG_IN_EN_O))
        else $error("pull-high kept on an analog pin");
    a_ref_pair: assert property (REF_EXT_SEL_O == VREF_PIN_SHARED_DIS_O)
        else $error("reference pin functions not tied to reference select");
    a_power_reset: assert property (!CONV_POWER_ON_O ##1 !CONV_POWER_ON_O |-> CONV_RESET_O)
        else $error("converter left running while powered down");
    a_start_hold: assert property (wr_go |=> CONV_RESET_O)
        else $error("start high did not hold the converter in reset");
    a_chan_route: assert property (wr_cmd ##1 !wr_cmd ##1 !wr_cmd |->
        CHANNEL_SEL_O == $past(ch_w, 2)) else $error("channel select not routed");
    a_done_pulse: assert property (CONV_DONE_O |=> !CONV_DONE_O)
        else $error("completion pulse longer than one cycle");
    a_done_reset: assert property (CONV_DONE_O |-> CONV_RESET_O)
        else $error("converter still running after completion");
    a_int_cause: assert property ($rose(INT_O) |-> CONV_DONE_O ||
        $past(wr_int, 1) || $past(wr_int, 2)) else $error("interrupt without a cause");
    // main scenarios
    c_done: cover property (CONV_DONE_O);
    c_int: cover property (CONV_DONE_O && INT_O);
    c_off: cover property (!CONV_POWER_ON_O);
endmodule // acc_ctrl_checker
`default_nettype wire

/* testbench/test_acc_ctrl.sv */
// test_acc_ctrl: self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_acc_ctrl
    import acc_pkg::*;
;
    localparam int SETTLE = 20;  // power-up settling wait, length arbitrary
    logic CLOCK_I = 0, SRST_I = 1, WR_I = 0, RD_I = 0, COMPARE_I;
    logic CONV_POWER_ON_O, CONV_RESET_O, REF_EXT_SEL_O, VREF_PIN_SHARED_DIS_O;
    logic CONV_DONE_O, INT_O;
    logic [2:0] ADDR_I = 0, CHANNEL_SEL_O;
    logic [7:0] WDATA_I = 0, RDATA_O;
    logic [5:0] PORT_DIR_OE_I = 0, PULLUP_EN_I = 0, ANALOG_IN_EN_O, PIN_OUT_EN_O, PULLUP_ON_O;
    logic [11:0] DAC_TRIAL_O, level = 0;
    int n_mismatch = 0, compares = 0;
    // 10 MHz system clock
    always #50 CLOCK_I = ~CLOCK_I;
    acc_ctrl acc_ctrl_i (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .COMPARE_I(COMPARE_I), .PORT_DIR_OE_I(PORT_DIR_OE_I), .PULLUP_EN_I(PULLUP_EN_I),
        .DAC_TRIAL_O(DAC_TRIAL_O), .CHANNEL_SEL_O(CHANNEL_SEL_O),
        .CONV_POWER_ON_O(CONV_POWER_ON_O), .CONV_RESET_O(CONV_RESET_O),
        .REF_EXT_SEL_O(REF_EXT_SEL_O), .VREF_PIN_SHARED_DIS_O(VREF_PIN_SHARED_DIS_O),
        .ANALOG_IN_EN_O(ANALOG_IN_EN_O), .PIN_OUT_EN_O(PIN_OUT_EN_O),
        .PULLUP_ON_O(PULLUP_ON_O), .CONV_DONE_O(CONV_DONE_O), .INT_O(INT_O));
    acc_analog_model acc_analog_model_i (.trial_i(DAC_TRIAL_O), .level_i(level),
        .chan_i(CHANNEL_SEL_O), .compare_o(COMPARE_I));
    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one-cycle bus strobes, taken at the edge where the task returns
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLOCK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CLOCK_I);
        WR_I <= 1'b0;
    endtask
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] ex, input string nm);
        @(posedge CLOCK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLOCK_I);
        RD_I <= 1'b0;
        #1;
        `CHK(nm, ex, RDATA_O)
    endtask
    // full conversion: divider, channel, start pulse, then time and result
    task automatic conv(input logic [2:0] div, input int n, input logic [2:0] ch,
                        input logic [11:0] lv, input logic ei);
        int k;
        level <= lv;
        wr(ACC_OFS_SETUP, {5'h00, div});
        wr(ACC_OFS_CMD, {5'h10, ch});
        wr(ACC_OFS_CMD, {5'h00, ch});
        for (k = 1; k <= 1100; k++) begin
            @(posedge CLOCK_I);
            #1;
            if (CONV_DONE_O === 1'b1) break;
        end
        if (k > 1100) begin
            n_mismatch++;
            results();
        end
        `CHK("conversion cycles", 16 * n + 1, k)
        `CHK("interrupt at completion", ei, INT_O)
        chk_rd(ACC_OFS_CMD, {5'h00, ch}, "flag after completion");
        chk_rd(ACC_OFS_RES_LO, lv[7:0] ^ {5'h00, ch}, "result low");
        chk_rd(ACC_OFS_RES_HI, {4'h0, lv[11:8]}, "result high");
    endtask
    task automatic t_reset();
        @(posedge CLOCK_I);  // outputs settle at the first edge after release
        #1;
        `CHK("power after reset", 1'b1, CONV_POWER_ON_O)
        `CHK("held after reset", 1'b1, CONV_RESET_O)
        chk_rd(ACC_OFS_CMD, 8'h40, "command reset");
        chk_rd(ACC_OFS_SETUP, 8'h80, "setup reset");
        chk_rd(ACC_OFS_PINS, 8'h00, "pins reset");
        chk_rd(ACC_OFS_INT, 8'h00, "interrupt reset");
        chk_rd(3'h6, 8'h00, "unmapped read");
    endtask
    // every divider code, every channel, the full-scale end of the code range
    task automatic t_dividers();
        logic [2:0] codes [8] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2, 3'h3, 3'h7};
        int ns [8] = '{1, 2, 4, 8, 16, 32, 32, 32};
        for (int i = 0; i < 8; i++) begin
            conv(codes[i], ns[i], 3'(i), (i == 0) ? 12'hfff : 12'(i * 12'h5a1), 1'b0);
        end
    endtask
    // all enable combinations; only all three set reach the processor
    task automatic t_irq();
        for (int e = 0; e < 8; e++) begin
            wr(ACC_OFS_INT, {5'h00, 3'(e)});
            conv(ACC_DIV_1, 1, 3'h0, 12'h123, e == 7);
            chk_rd(ACC_OFS_INT, {4'h0, 1'b1, 3'(e)}, "request set");
            wr(ACC_OFS_INT, {5'h00, 3'(e)});
            repeat (2) @(posedge CLOCK_I);
            #1;
            `CHK("interrupt after clear", 1'b0, INT_O)
        end
    endtask
    task automatic t_pins();
        @(posedge CLOCK_I);
        PORT_DIR_OE_I <= 6'h3c;
        PULLUP_EN_I <= 6'h33;
        wr(ACC_OFS_PINS, 8'h2a);
        wr(ACC_OFS_SETUP, 8'h20);
        repeat (2) @(posedge CLOCK_I);
        #1;
        `CHK("analog enables", 6'h2a, ANALOG_IN_EN_O)
        `CHK("pin drive", 6'h14, PIN_OUT_EN_O)
        `CHK("pull-highs", 6'h11, PULLUP_ON_O)
        `CHK("external reference", 1'b1, REF_EXT_SEL_O)
        `CHK("reference pin shared off", 1'b1, VREF_PIN_SHARED_DIS_O)
        chk_rd(ACC_OFS_SETUP, 8'ha0, "setup readback");
    endtask
    // a new start mid-conversion holds the converter; nothing completes until released
    task automatic t_abort();
        logic seen;
        seen = 1'b0;
        wr(ACC_OFS_SETUP, {5'h00, ACC_DIV_32});
        wr(ACC_OFS_CMD, 8'h80);
        wr(ACC_OFS_CMD, 8'h00);
        repeat (40) @(posedge CLOCK_I);
        #1;
        `CHK("running before restart", 1'b0, CONV_RESET_O)
        wr(ACC_OFS_CMD, 8'h80);
        repeat (2) @(posedge CLOCK_I);
        #1;
        `CHK("held by restart", 1'b1, CONV_RESET_O)
        repeat (600) begin
            @(posedge CLOCK_I);
            #1;
            seen = seen | CONV_DONE_O;
        end
        `CHK("completion while held", 1'b0, seen)
        chk_rd(ACC_OFS_CMD, 8'hc0, "flag while held");
        conv(ACC_DIV_1, 1, 3'h0, 12'h000, 1'b1);
    endtask
    // start while powered down gives nothing; after power-up it converts again
    task automatic t_power();
        logic seen;
        seen = 1'b0;
        wr(ACC_OFS_SETUP, 8'h44);
        wr(ACC_OFS_CMD, 8'h80);
        wr(ACC_OFS_CMD, 8'h00);
        repeat (40) begin
            @(posedge CLOCK_I);
            #1;
            seen = seen | CONV_DONE_O;
        end
        `CHK("powered", 1'b0, CONV_POWER_ON_O)
        `CHK("completion while off", 1'b0, seen)
        chk_rd(ACC_OFS_CMD, 8'h40, "flag while off");
        wr(ACC_OFS_SETUP, 8'h04);
        repeat (SETTLE) @(posedge CLOCK_I);
        conv(ACC_DIV_1, 1, 3'h3, 12'h7ff, 1'b1);
        wr(ACC_OFS_SETUP, 8'h44);
    endtask
    initial begin
        repeat (12) @(posedge CLOCK_I);
        SRST_I <= 1'b0;
        t_reset();
        t_dividers();
        t_irq();
        t_pins();
        t_abort();
        t_power();
        results();
    end
endmodule // test_acc_ctrl
bind acc_ctrl acc_ctrl_checker acc_ctrl_checker_i (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .PORT_DIR_OE_I(PORT_DIR_OE_I),
    .PULLUP_EN_I(PULLUP_EN_I), .CHANNEL_SEL_O(CHANNEL_SEL_O),
    .CONV_POWER_ON_O(CONV_POWER_ON_O), .CONV_RESET_O(CONV_RESET_O),
    .REF_EXT_SEL_O(REF_EXT_SEL_O), .VREF_PIN_SHARED_DIS_O(VREF_PIN_SHARED_DIS_O),
    .ANALOG_IN_EN_O(ANALOG_IN_EN_O), .PIN_OUT_EN_O(PIN_OUT_EN_O),
    .PULLUP_ON_O(PULLUP_ON_O), .CONV_DONE_O(CONV_DONE_O), .INT_O(INT_O));
`default_nettype wire
